// *** rtl/csio_pkg.sv ***
// Package for the control-line digital I/O block
package csio_pkg;
    localparam int NUM_IN     = 3;
    localparam int NUM_OUT    = 2;
    localparam int NUM_NOTE   = 3;
    // Input index: DSR, DCD, CTS; output index: DTR, RTS
    localparam int IN_DSR     = 0;
    localparam int IN_DCD     = 1;
    localparam int IN_CTS     = 2;
    localparam int OUT_DTR    = 0;
    localparam int OUT_RTS    = 1;
    // Notification channel bit positions
    localparam int NOTE_EMAIL = 0;
    localparam int NOTE_SYSLG = 1;
    localparam int NOTE_TRAP  = 2;
    // Severity code for alarm events (critical)
    localparam logic [2:0] SEV_CRITICAL = 3'h2;
    // Failsafe period, parameter default in cycles
    localparam int FS_TIMEOUT_US = 1000;
    localparam int CLK_MHZ       = 200;
    localparam int FS_CYCLES     = FS_TIMEOUT_US * CLK_MHZ;
    localparam int FS_W          = 32;

    typedef enum logic [1:0] {
        CSIO_LATCH_NONE = 2'h0,
        CSIO_LATCH_RISE = 2'h1,
        CSIO_LATCH_FALL = 2'h2
    } csio_latch_e;

    typedef enum logic [1:0] {
        CSIO_TRIG_OFF      = 2'h0,
        CSIO_TRIG_INACTIVE = 2'h1,
        CSIO_TRIG_ACTIVE   = 2'h2
    } csio_trig_e;

    typedef enum logic [1:0] {
        CSIO_FS_NONE  = 2'h0,
        CSIO_FS_SET   = 2'h1,
        CSIO_FS_CLEAR = 2'h2
    } csio_fs_e;

    // Per-input configuration
    typedef struct packed {
        logic        enable;
        csio_latch_e latch;
        logic        invert;
        csio_trig_e  trig;
        logic        manual;
    } csio_in_cfg_s;

    // One alarm event to the notifier
    typedef struct packed {
        logic                valid;
        logic                raised;
        logic [1:0]          chan;
        logic                value;
        logic [2:0]          severity;
        logic [NUM_NOTE-1:0] route;
    } csio_event_s;

    localparam logic [NUM_IN-1:0] RST_IN = 3'h0;
endpackage

// *** rtl/csio_top.sv ***
// Control-line digital I/O core: inputs, alarms, failsafe outputs
`timescale 1ns/10ps
module csio_top #(
    parameter int FS_CYCLES_P = csio_pkg::FS_CYCLES
) (
    // Clock and reset
    input  wire logic                              CLOCK,
    input  wire logic                              RST_B,
    input  wire logic                              CLK_EN,
    // Profile and channel enables
    input  wire logic                              PROFILE_SEL,
    input  wire logic [csio_pkg::NUM_OUT-1:0]      OUT_EN,
    // Input configuration
    input  csio_pkg::csio_in_cfg_s [csio_pkg::NUM_IN-1:0] IN_CFG,
    input  wire logic [csio_pkg::NUM_NOTE-1:0]     NOTE_EN,
    input  wire logic [csio_pkg::NUM_IN-1:0]       ALARM_CLR,
    input  wire logic [csio_pkg::NUM_IN-1:0]       LATCH_CLR,
    // Output commands
    input  wire logic [csio_pkg::NUM_OUT-1:0]      OUT_WR,
    input  wire logic [csio_pkg::NUM_OUT-1:0]      OUT_VAL,
    input  csio_pkg::csio_fs_e [csio_pkg::NUM_OUT-1:0] FS_ACT,
    // Serial port pins
    input  wire logic [csio_pkg::NUM_IN-1:0]       LINE_IN,
    output logic      [csio_pkg::NUM_OUT-1:0]      LINE_OUT,
    output logic      [csio_pkg::NUM_OUT-1:0]      LINE_OE,
    // Status and events
    output logic      [csio_pkg::NUM_IN-1:0]       IN_STATUS,
    output logic      [csio_pkg::NUM_IN-1:0]       ALARM,
    output logic                                   FS_EXPIRED,
    output csio_pkg::csio_event_s                  EVENT
);
    import csio_pkg::*;

    localparam logic [FS_W-1:0] FS_LAST = FS_W'(FS_CYCLES_P - 1);

    logic [NUM_IN-1:0]  s1_q, s2_q, s3_q;
    logic [NUM_IN-1:0]  line_q;
    logic [NUM_IN-1:0]  in_act;
    logic [NUM_IN-1:0]  line_d;
    logic [NUM_IN-1:0]  rise, fall;
    logic [NUM_IN-1:0]  raise, drop;
    logic [NUM_IN-1:0]  latch_q;
    logic [NUM_IN-1:0]  alarm_q;
    logic [NUM_OUT-1:0] out_q;
    logic [FS_W-1:0]    fs_cnt_q;
    logic               fs_q;
    logic               activity;
    logic               fs_fire;
    csio_event_s        ev_q;

    // Three-stage sync; change taken when stages two and three agree
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            s1_q <= RST_IN;
            s2_q <= RST_IN;
            s3_q <= RST_IN;
        end else if (CLK_EN) begin
            s1_q <= LINE_IN;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Per-input decode
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            // Disabled or unselected input is held inactive
            assign in_act[gi] = PROFILE_SEL & IN_CFG[gi].enable;
            assign line_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi]
                                                       : line_q[gi];
            assign rise[gi]   = in_act[gi] & line_d[gi] & ~line_q[gi];
            assign fall[gi]   = in_act[gi] & ~line_d[gi] & line_q[gi];
            // Alarm raise on selected edge only
            assign raise[gi]  = ~alarm_q[gi] & (
                (IN_CFG[gi].trig == CSIO_TRIG_INACTIVE & fall[gi]) |
                (IN_CFG[gi].trig == CSIO_TRIG_ACTIVE   & rise[gi]));
            // Manual bit set selects manual, clear selects auto
            assign drop[gi]   = alarm_q[gi] & ~raise[gi] & (
                (IN_CFG[gi].manual ? ALARM_CLR[gi] :
                 ((IN_CFG[gi].trig == CSIO_TRIG_INACTIVE & rise[gi]) |
                  (IN_CFG[gi].trig == CSIO_TRIG_ACTIVE   & fall[gi]))) |
                (IN_CFG[gi].trig == CSIO_TRIG_OFF));
            // Status: latched occurrence or live level, optionally inverted
            assign IN_STATUS[gi] = ~in_act[gi] ? 1'b0 :
                ((IN_CFG[gi].latch == CSIO_LATCH_NONE) ? line_q[gi]
                                                       : latch_q[gi])
                ^ IN_CFG[gi].invert;
        end
    endgenerate

    // Debounced line level, latches and alarms
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            line_q  <= RST_IN;
            latch_q <= RST_IN;
            alarm_q <= RST_IN;
        end else if (CLK_EN) begin
            line_q  <= line_d;
            for (int i = 0; i < NUM_IN; i++) begin
                // Set wins over clear
                if ((IN_CFG[i].latch == CSIO_LATCH_RISE & rise[i]) |
                    (IN_CFG[i].latch == CSIO_LATCH_FALL & fall[i]))
                    latch_q[i] <= 1'b1;
                else if (LATCH_CLR[i] | IN_CFG[i].latch == CSIO_LATCH_NONE)
                    latch_q[i] <= 1'b0;
                if (raise[i])
                    alarm_q[i] <= 1'b1;
                else if (drop[i])
                    alarm_q[i] <= 1'b0;
            end
        end
    end

    // Lowest-index input wins an event slot in a cycle; the rest are
    // reported from ALARM level only
    logic [1:0] ev_idx;
    logic       ev_any;
    always_comb begin
        ev_idx = 2'h0;
        ev_any = 1'b0;
        for (int i = NUM_IN - 1; i >= 0; i--) begin
            if (raise[i] | drop[i]) begin
                ev_idx = 2'(i);
                ev_any = 1'b1;
            end
        end
    end

    // Event register
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            ev_q <= '0;
        end else if (CLK_EN) begin
            ev_q.valid    <= ev_any & (|NOTE_EN);
            ev_q.raised   <= raise[ev_idx];
            ev_q.chan     <= ev_idx;
            ev_q.value    <= line_d[ev_idx] ^ IN_CFG[ev_idx].invert;
            ev_q.severity <= SEV_CRITICAL;
            ev_q.route    <= NOTE_EN;
        end
    end

    // Failsafe timer restarts on any activity
    assign activity = (|(rise | fall)) | (|OUT_WR);
    assign fs_fire  = ~fs_q & ~activity & (fs_cnt_q == FS_LAST);

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            fs_cnt_q <= '0;
            fs_q     <= 1'b0;
        end else if (CLK_EN) begin
            if (activity) begin
                fs_cnt_q <= '0;
                fs_q     <= 1'b0;
            end else if (fs_fire) begin
                fs_q     <= 1'b1;
            end else if (!fs_q) begin
                fs_cnt_q <= fs_cnt_q + 1'b1;
            end
        end
    end

    // Output latches: command wins over failsafe
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            out_q <= '0;
        end else if (CLK_EN) begin
            for (int j = 0; j < NUM_OUT; j++) begin
                if (OUT_WR[j])
                    out_q[j] <= OUT_VAL[j];
                else if (fs_fire & FS_ACT[j] == CSIO_FS_SET)
                    out_q[j] <= 1'b1;
                else if (fs_fire & FS_ACT[j] == CSIO_FS_CLEAR)
                    out_q[j] <= 1'b0;
            end
        end
    end

    // Disabled output is not driven
    assign LINE_OE    = {NUM_OUT{PROFILE_SEL}} & OUT_EN;
    assign LINE_OUT   = out_q & LINE_OE;
    assign ALARM      = alarm_q;
    assign FS_EXPIRED = fs_q;
    assign EVENT      = ev_q;

    // Assertions
    property p_raise_act;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & in_act[0] & IN_CFG[0].trig == CSIO_TRIG_ACTIVE &
         ~alarm_q[0] & rise[0]) |=> alarm_q[0];
    endproperty
    a_raise_act: assert property (p_raise_act)
        else $error("active trigger missed");

    property p_raise_inact;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & IN_CFG[1].trig == CSIO_TRIG_INACTIVE & fall[1] &
         ~alarm_q[1]) |=> alarm_q[1];
    endproperty
    a_raise_inact: assert property (p_raise_inact)
        else $error("inactive trigger missed");

    property p_off;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & IN_CFG[0].trig == CSIO_TRIG_OFF) |=> ~alarm_q[0];
    endproperty
    a_off: assert property (p_off)
        else $error("alarm raised while disabled");

    property p_manual;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & alarm_q[1] & IN_CFG[1].manual & ~ALARM_CLR[1] &
         IN_CFG[1].trig != CSIO_TRIG_OFF) |=> alarm_q[1];
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual alarm cleared without request");

    property p_auto;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & alarm_q[0] & ~IN_CFG[0].manual &
         IN_CFG[0].trig == CSIO_TRIG_ACTIVE & fall[0]) |=> ~alarm_q[0];
    endproperty
    a_auto: assert property (p_auto)
        else $error("auto clear missed");

    // Raise on input 0 always wins the event slot, being lowest index
    sequence s_raise0;
        CLK_EN & raise[0] & (|NOTE_EN);
    endsequence
    sequence s_ev_up;
        EVENT.valid & EVENT.raised & EVENT.chan == 2'h0 &
        EVENT.severity == SEV_CRITICAL;
    endsequence
    property p_event;
        @(posedge CLOCK) disable iff (!RST_B)
        s_raise0 |=> s_ev_up;
    endproperty
    a_event: assert property (p_event)
        else $error("raise event missing");

    property p_fs;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & fs_fire & ~OUT_WR[0] & FS_ACT[0] == CSIO_FS_SET)
            |=> out_q[0];
    endproperty
    a_fs: assert property (p_fs)
        else $error("failsafe activate missed");

    property p_restart;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & activity) |=> (fs_cnt_q == '0 & ~fs_q);
    endproperty
    a_restart: assert property (p_restart)
        else $error("failsafe timer not restarted");

    property p_oe;
        @(posedge CLOCK) disable iff (!RST_B)
        ~OUT_EN[1] |-> ~LINE_OE[1] & ~LINE_OUT[1];
    endproperty
    a_oe: assert property (p_oe)
        else $error("disabled output driven");

    // Clear event follows a dropped alarm on the next edge
    sequence s_drop0;
        CLK_EN & drop[0] & (|NOTE_EN);
    endsequence
    sequence s_ev_down;
        EVENT.valid & ~EVENT.raised & EVENT.chan == 2'h0 &
        EVENT.severity == SEV_CRITICAL;
    endsequence
    property p_drop_ev;
        @(posedge CLOCK) disable iff (!RST_B)
        s_drop0 |=> s_ev_down;
    endproperty
    a_drop_ev: assert property (p_drop_ev)
        else $error("clear event missing");

    property p_quiet;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & NOTE_EN == '0) |=> ~EVENT.valid;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("event sent with all channels off");

    // Latched transition stays until cleared or latch set to none
    property p_latch_hold;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & latch_q[2] & ~LATCH_CLR[2] &
         IN_CFG[2].latch != CSIO_LATCH_NONE) |=> latch_q[2];
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched status lost");

    property p_latch_fall;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & IN_CFG[2].latch == CSIO_LATCH_FALL & fall[2])
            |=> latch_q[2];
    endproperty
    a_latch_fall: assert property (p_latch_fall)
        else $error("falling transition not latched");

    property p_fs_clr;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & fs_fire & ~OUT_WR[1] & FS_ACT[1] == CSIO_FS_CLEAR)
            |=> ~out_q[1];
    endproperty
    a_fs_clr: assert property (p_fs_clr)
        else $error("failsafe deactivate missed");

    // Disabled input never raises an alarm
    property p_in_off;
        @(posedge CLOCK) disable iff (!RST_B)
        (CLK_EN & ~in_act[1] & ~alarm_q[1]) |=> ~alarm_q[1];
    endproperty
    a_in_off: assert property (p_in_off)
        else $error("alarm raised on disabled input");

    // Enable low must freeze the timer, so idle time is not lost
    property p_freeze;
        @(posedge CLOCK) disable iff (!RST_B)
        ~CLK_EN |=> ($stable(fs_cnt_q) & $stable(alarm_q) &
                     $stable(latch_q));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");
endmodule

// *** sim/csio_peer.sv ***
// Far-side equipment model on the serial control lines
`timescale 1ns/10ps
module csio_peer (
    // Clock
    input  wire logic                         clock,
    // Lines toward the block
    output logic      [csio_pkg::NUM_IN-1:0]  line_in,
    input  wire logic [csio_pkg::NUM_OUT-1:0] line_out,
    input  wire logic [csio_pkg::NUM_OUT-1:0] line_oe,
    // Level the equipment sees
    output logic      [csio_pkg::NUM_OUT-1:0] seen
);
    import csio_pkg::*;
    logic [NUM_IN-1:0]  lvl_q  = '0;
    logic [NUM_OUT-1:0] last_q = '0;
    // Status lines are driven here, control lines only watched
    assign line_in = lvl_q;
    // Undriven line toggles so a stale level never looks valid
    assign seen = (line_oe & line_out) | (~line_oe & ~last_q);
    always_ff @(posedge clock) begin
        last_q <= seen;
    end
    // Change one status line just after an edge
    task automatic set_line(input int idx, input logic val);
        @(posedge clock);
        lvl_q[idx] <= val;
    endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the control-line digital I/O block
`timescale 1ns/10ps
module testbench;
    import csio_pkg::*;
    logic clk = 0;
    logic rst_b = 0;
    logic clk_en = 1;
    logic prof = 0;
    logic [1:0] out_en = 2'h3;
    csio_in_cfg_s [2:0] in_cfg = '0;
    logic [2:0] note_en = 3'h0;
    logic [2:0] alarm_clr = 3'h0;
    logic [2:0] latch_clr = 3'h0;
    logic [1:0] out_wr = 2'h0;
    logic [1:0] out_val = 2'h0;
    csio_fs_e [1:0] fs_act = '{CSIO_FS_NONE, CSIO_FS_NONE};
    logic [2:0] line_in, in_status, alarm;
    logic [1:0] line_out, line_oe, seen;
    logic fs_exp;
    csio_event_s event_o, last_ev;
    int n_fail = 0;
    int n_compared = 0;
    int n_ev = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    csio_top #(.FS_CYCLES_P(20)) i_dut (
        .CLOCK(clk), .RST_B(rst_b), .CLK_EN(clk_en), .PROFILE_SEL(prof),
        .OUT_EN(out_en), .IN_CFG(in_cfg), .NOTE_EN(note_en),
        .ALARM_CLR(alarm_clr), .LATCH_CLR(latch_clr), .OUT_WR(out_wr),
        .OUT_VAL(out_val), .FS_ACT(fs_act), .LINE_IN(line_in),
        .LINE_OUT(line_out), .LINE_OE(line_oe), .IN_STATUS(in_status),
        .ALARM(alarm), .FS_EXPIRED(fs_exp), .EVENT(event_o));
    csio_peer i_peer (.clock(clk), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe), .seen(seen));
    // Catch one-cycle events as they pass
    always @(posedge clk) begin
        if (event_o.valid === 1'b1) begin
            last_ev <= event_o;
            n_ev <= n_ev + 1;
        end
    end
    task automatic check(input string what, input logic [15:0] got,
                         input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Let n edges pass, then sample on the falling edge
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic cfg(input int i, input logic en, input csio_latch_e la,
                       input logic inv, input csio_trig_e tr, input logic man);
        @(posedge clk);
        in_cfg[i] <= '{enable: en, latch: la, invert: inv, trig: tr,
                       manual: man};
    endtask
    // Pin change needs 4 edges to land, event on that same edge
    task automatic pin(input int i, input logic v);
        i_peer.set_line(i, v);
        wait_n(8);
    endtask
    task automatic out_cmd(input logic [1:0] v);
        @(posedge clk);
        out_wr <= 2'h3;
        out_val <= v;
        @(posedge clk);
        out_wr <= 2'h0;
    endtask
    function automatic csio_event_s ev(input logic r, input logic [1:0] c,
                                       input logic v, input logic [2:0] rt);
        return '{valid: 1'b1, raised: r, chan: c, value: v,
                 severity: SEV_CRITICAL, route: rt};
    endfunction
    task automatic t_outputs();
        check("oe_noprof", line_oe, 2'h0);
        check("alarm_rst", alarm, 3'h0);
        @(posedge clk);
        prof <= 1'b1;
        out_cmd(2'h2);
        wait_n(2);
        check("oe", line_oe, 2'h3);
        check("out", line_out, 2'h2);
        @(posedge clk);
        out_en <= 2'h1;
        wait_n(2);
        check("oe_dis", line_oe, 2'h1);
        check("out_dis", line_out, 2'h0);
        @(posedge clk);
        out_en <= 2'h3;
    endtask
    task automatic t_status();
        cfg(0, 1'b1, CSIO_LATCH_NONE, 1'b1, CSIO_TRIG_OFF, 1'b0);
        pin(1, 1'b1);
        check("inv_lo", in_status[0], 1'b1);
        check("dis_in", in_status[1], 1'b0);
        pin(0, 1'b1);
        check("inv_hi", in_status[0], 1'b0);
        pin(0, 1'b0);
        cfg(2, 1'b1, CSIO_LATCH_RISE, 1'b0, CSIO_TRIG_OFF, 1'b0);
        pin(2, 1'b1);
        pin(2, 1'b0);
        check("latch", in_status[2], 1'b1);
        @(posedge clk);
        latch_clr <= 3'h4;
        @(posedge clk);
        latch_clr <= 3'h0;
        wait_n(2);
        check("latch_clr", in_status[2], 1'b0);
        cfg(2, 1'b1, CSIO_LATCH_FALL, 1'b0, CSIO_TRIG_OFF, 1'b0);
        pin(2, 1'b1);
        check("fall_rise", in_status[2], 1'b0);
        pin(2, 1'b0);
        check("fall_latch", in_status[2], 1'b1);
    endtask
    task automatic t_alarm_auto();
        cfg(0, 1'b1, CSIO_LATCH_NONE, 1'b0, CSIO_TRIG_ACTIVE, 1'b0);
        @(posedge clk);
        note_en <= 3'h5;
        pin(0, 1'b1);
        check("raise", alarm[0], 1'b1);
        check("ev_n", n_ev[3:0], 4'h1);
        check("ev_up", last_ev, ev(1'b1, 2'h0, 1'b1, 3'h5));
        pin(0, 1'b0);
        check("autoclr", alarm[0], 1'b0);
        check("ev_dn", last_ev, ev(1'b0, 2'h0, 1'b0, 3'h5));
        @(posedge clk);
        note_en <= 3'h0;
        pin(0, 1'b1);
        check("ev_off", n_ev[3:0], 4'h2);
        pin(0, 1'b0);
    endtask
    // Clock enable low freezes the pin path; release lets it through
    task automatic t_freeze();
        @(posedge clk);
        clk_en <= 1'b0;
        pin(0, 1'b1);
        check("frozen", alarm[0], 1'b0);
        @(posedge clk);
        clk_en <= 1'b1;
        wait_n(8);
        check("thawed", alarm[0], 1'b1);
        pin(0, 1'b0);
        check("thaw_clr", alarm[0], 1'b0);
    endtask
    task automatic t_alarm_manual();
        cfg(1, 1'b1, CSIO_LATCH_NONE, 1'b0, CSIO_TRIG_INACTIVE, 1'b1);
        @(posedge clk);
        note_en <= 3'h2;
        wait_n(4);
        check("quiet", alarm[1], 1'b0);
        pin(1, 1'b0);
        check("fall", alarm[1], 1'b1);
        check("ev_fall", last_ev, ev(1'b1, 2'h1, 1'b0, 3'h2));
        pin(1, 1'b1);
        check("hold", alarm[1], 1'b1);
        @(posedge clk);
        alarm_clr <= 3'h2;
        @(posedge clk);
        alarm_clr <= 3'h0;
        wait_n(3);
        check("mclr", alarm[1], 1'b0);
        cfg(1, 1'b1, CSIO_LATCH_NONE, 1'b0, CSIO_TRIG_INACTIVE, 1'b0);
        pin(1, 1'b0);
        check("auto_fall", alarm[1], 1'b1);
        pin(1, 1'b1);
        check("auto_rise", alarm[1], 1'b0);
        check("ev_clr", last_ev, ev(1'b0, 2'h1, 1'b1, 3'h2));
        cfg(1, 1'b1, CSIO_LATCH_NONE, 1'b0, CSIO_TRIG_OFF, 1'b0);
        pin(1, 1'b0);
        check("trig_off", alarm[1], 1'b0);
    endtask
    task automatic t_failsafe();
        @(posedge clk);
        fs_act[0] <= CSIO_FS_SET;
        fs_act[1] <= CSIO_FS_CLEAR;
        out_cmd(2'h2);
        wait_n(10);
        out_cmd(2'h2);
        wait_n(12);
        check("fs_restart", fs_exp, 1'b0);
        wait_n(15);
        check("fs_exp", fs_exp, 1'b1);
        check("fs_out", line_out, 2'h1);
        check("fs_seen", seen, 2'h1);
        @(posedge clk);
        fs_act <= '{CSIO_FS_NONE, CSIO_FS_NONE};
        out_cmd(2'h2);
        wait_n(30);
        check("fs_none", line_out, 2'h2);
    endtask
    // Main sequence: reset for 20 cycles, then the scenarios
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        wait_n(2);
        t_outputs();
        t_status();
        t_alarm_auto();
        t_freeze();
        t_alarm_manual();
        t_failsafe();
        test_done();
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule
